//--- hdl/tcc_block.sv
// Three-channel 16-bit timer block with AXI4-Lite register access
`timescale 1ns/100ps
`include "tcc_defs.svh"
module tcc_block #(
    parameter int WIDTH = 16,
    parameter int CHANNELS = 3
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] timerClkPin,
    input wire logic [2:0] multiIoAIn,
    input wire logic [2:0] multiIoBIn,
    input wire logic [2:0] loadB,
    output logic [2:0] multiIoAOut,
    output logic [2:0] multiIoAOe,
    output logic [2:0] multiIoBOe,
    output logic [2:0] chanIrq
);
    typedef struct packed {
        tcc_pkg::tcc_bus_st_t wrSt;
        tcc_pkg::tcc_bus_st_t rdSt;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bResp;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [`TCC_DIV_W-1:0] div;
        logic [5:0] blockMode;
        logic [2:0] waveLevel;
        logic [2:0] sync;
        tcc_pkg::tcc_mode_t [2:0] mode;
        tcc_pkg::tcc_cmd_t [2:0] cmd;
        logic [2:0][WIDTH-1:0] matchC;
        logic [2:0][2:0] irqMask;
        logic [2:0][2:0] stat;
    } tcc_top_state_t;

    tcc_top_state_t st;
    tcc_top_state_t next_st;
    logic [4:0] tapPulse;
    logic [2:0][2:0] extClk;
    logic [2:0][WIDTH-1:0] countValue;
    logic [2:0] clkOnStatus;
    logic [2:0] wrapEvt;
    logic [2:0] matchCEvt;
    logic [`TCC_DIV_W-1:0] divNext;

    // Channel index from address, or TCC_CHAN_SPAN (3) when not a channel register
    function automatic logic [1:0] chanOf(input logic [7:0] addr);
        logic [7:0] base;
        begin
            base = addr & ~(`TCC_CHAN_STRIDE - 8'h01);
            chanOf = `TCC_CHAN_SPAN;
            if (base == 8'h00)
                chanOf = 2'h0;
            else if (base == `TCC_CHAN_STRIDE)
                chanOf = 2'h1;
            else if (base == 8'(`TCC_CHAN_STRIDE * 2))
                chanOf = 2'h2;
        end
    endfunction

    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        begin
            res = old;
            for (int i = 0; i < 4; i++)
                if (strb[i])
                    res[i*8 +: 8] = nw[i*8 +: 8];
            mergeStrb = res;
        end
    endfunction

    // Waveform bit sits apart from the low mode fields in the register word
    function automatic tcc_pkg::tcc_mode_t modeOf(input logic [31:0] w);
        begin
            modeOf = tcc_pkg::tcc_mode_t'({w[`TCC_MODE_WAVE], w[`TCC_MODE_OFF_C:`TCC_MODE_SEL_LO]});
        end
    endfunction

    function automatic logic [31:0] modeWord(input tcc_pkg::tcc_mode_t m);
        logic [31:0] w;
        begin
            w = 32'h0000_0000;
            w[`TCC_MODE_OFF_C:`TCC_MODE_SEL_LO] = m[`TCC_MODE_OFF_C:`TCC_MODE_SEL_LO];
            w[`TCC_MODE_WAVE] = m.wave;
            modeWord = w;
        end
    endfunction

    assign divNext = st.div + 1'b1;
    assign tapPulse[0] = divNext[0] & ~st.div[0];
    assign tapPulse[1] = divNext[2] & ~st.div[2];
    assign tapPulse[2] = divNext[4] & ~st.div[4];
    assign tapPulse[3] = divNext[6] & ~st.div[6];
    assign tapPulse[4] = divNext[9] & ~st.div[9];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : gChan
            // pin or chained output A per external input
            for (genvar k = 0; k < 3; k++)
            begin : gExt
                assign extClk[g][k] = st.blockMode[2*k] ?
                    (st.blockMode[2*k+1] ? multiIoAOut[(k+2)%3] : multiIoAOut[(k+1)%3]) :
                    timerClkPin[k];
            end
            tcc_channel #(
                .WIDTH(WIDTH)
            ) uChan (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .tapPulse(tapPulse),
                .extClkIn(extClk[g]),
                .mode(st.mode[g]),
                .cmd(st.cmd[g]),
                .syncIn(st.sync[g]),
                .matchC(st.matchC[g]),
                .loadB(loadB[g]),
                .countValue(countValue[g]),
                .clkOnStatus(clkOnStatus[g]),
                .wrapEvt(wrapEvt[g]),
                .matchCEvt(matchCEvt[g])
            );
            // output A driven only in waveform mode
            assign multiIoAOe[g] = st.mode[g].wave;
            assign multiIoAOut[g] = st.waveLevel[g];
            assign multiIoBOe[g] = 1'b0;
            assign chanIrq[g] = |(st.stat[g] & st.irqMask[g]);
        end
    endgenerate

    always_comb
    begin
        logic [1:0] ch;
        logic [7:0] ofs;
        next_st = st;
        ch = 2'h0;
        ofs = 8'h00;
        next_st.div = divNext;
        next_st.cmd = '0;
        next_st.sync = '0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            // sticky wrap, load B and match C flags, set wins over read-clear
            if (wrapEvt[i])
                next_st.stat[i][`TCC_STAT_WRAP] = 1'b1;
            if (loadB[i])
                next_st.stat[i][`TCC_STAT_LOADB] = 1'b1;
            if (matchCEvt[i])
            begin
                next_st.stat[i][`TCC_STAT_MATCHC] = 1'b1;
                next_st.waveLevel[i] = ~st.waveLevel[i];
            end
        end
        // Write channel: collect address and data in either order
        if (s_axi_awvalid & s_axi_awready)
        begin
            next_st.awHave = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            next_st.wHave = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        case (st.wrSt)
            tcc_pkg::TCC_B_IDLE:
                if (next_st.awHave & next_st.wHave)
                    next_st.wrSt = tcc_pkg::TCC_B_RUN;
            tcc_pkg::TCC_B_RUN:
            begin
                ch = chanOf(st.awAddr);
                ofs = st.awAddr & (`TCC_CHAN_STRIDE - 8'h01);
                next_st.bResp = `TCC_RESP_OKAY;
                if (ch != `TCC_CHAN_SPAN)
                begin
                    case (ofs)
                        `TCC_CTRL_OFS:
                        begin
                            next_st.cmd[ch].clkOnCmd = st.wData[`TCC_CTRL_ON] & st.wStrb[0];
                            next_st.cmd[ch].clkOffCmd = st.wData[`TCC_CTRL_OFF] & st.wStrb[0];
                            next_st.cmd[ch].softTriggerCmd = st.wData[`TCC_CTRL_TRIG] & st.wStrb[0];
                        end
                        `TCC_MODE_OFS:
                            next_st.mode[ch] = modeOf(mergeStrb(modeWord(st.mode[ch]), st.wData, st.wStrb));
                        `TCC_RC_OFS:
                            next_st.matchC[ch] = WIDTH'(mergeStrb(32'(st.matchC[ch]), st.wData, st.wStrb));
                        `TCC_STAT_OFS:
                            next_st.irqMask[ch] = st.wData[2:0];
                        default:
                            next_st.bResp = `TCC_RESP_SLVERR;
                    endcase
                end
                else if (st.awAddr == `TCC_BCTRL_OFS)
                begin
                    if (st.wData[`TCC_BCTRL_SYNC])
                        next_st.sync = 3'h7;
                end
                else if (st.awAddr == `TCC_BMODE_OFS)
                    next_st.blockMode = st.wData[5:0];
                else
                    next_st.bResp = `TCC_RESP_SLVERR;
                next_st.wrSt = tcc_pkg::TCC_B_RESP;
            end
            tcc_pkg::TCC_B_RESP:
                if (s_axi_bready)
                begin
                    next_st.awHave = 1'b0;
                    next_st.wHave = 1'b0;
                    next_st.wrSt = tcc_pkg::TCC_B_IDLE;
                end
            default:
                next_st.wrSt = tcc_pkg::TCC_B_IDLE;
        endcase
        case (st.rdSt)
            tcc_pkg::TCC_B_IDLE:
                if (s_axi_arvalid)
                begin
                    ch = chanOf(s_axi_araddr);
                    ofs = s_axi_araddr & (`TCC_CHAN_STRIDE - 8'h01);
                    next_st.rResp = `TCC_RESP_OKAY;
                    next_st.rData = 32'h0000_0000;
                    if (ch != `TCC_CHAN_SPAN)
                    begin
                        case (ofs)
                            `TCC_VALUE_OFS: next_st.rData = 32'(countValue[ch]);
                            `TCC_MODE_OFS: next_st.rData = modeWord(st.mode[ch]);
                            `TCC_RC_OFS: next_st.rData = 32'(st.matchC[ch]);
                            `TCC_CTRL_OFS: next_st.rData = 32'h0000_0000;
                            `TCC_STAT_OFS:
                            begin
                                next_st.rData = 32'(st.stat[ch]);
                                next_st.rData[`TCC_STAT_ON] = clkOnStatus[ch];
                                next_st.stat[ch] = {matchCEvt[ch], loadB[ch], wrapEvt[ch]};
                            end
                            default: next_st.rResp = `TCC_RESP_SLVERR;
                        endcase
                    end
                    else if (s_axi_araddr == `TCC_BMODE_OFS)
                        next_st.rData = 32'(st.blockMode);
                    else if (s_axi_araddr != `TCC_BCTRL_OFS)
                        next_st.rResp = `TCC_RESP_SLVERR;
                    next_st.rdSt = tcc_pkg::TCC_B_RESP;
                end
            tcc_pkg::TCC_B_RESP:
                if (s_axi_rready)
                    next_st.rdSt = tcc_pkg::TCC_B_IDLE;
            default:
                next_st.rdSt = tcc_pkg::TCC_B_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign s_axi_awready = ~st.awHave & (st.wrSt == tcc_pkg::TCC_B_IDLE);
    assign s_axi_wready = ~st.wHave & (st.wrSt == tcc_pkg::TCC_B_IDLE);
    assign s_axi_bvalid = st.wrSt == tcc_pkg::TCC_B_RESP;
    assign s_axi_bresp = st.bResp;
    assign s_axi_arready = st.rdSt == tcc_pkg::TCC_B_IDLE;
    assign s_axi_rvalid = st.rdSt == tcc_pkg::TCC_B_RESP;
    assign s_axi_rdata = st.rData;
    assign s_axi_rresp = st.rResp;
endmodule

//--- hdl/tcc_defs.svh
// Register offsets, field positions and timing constants of the timer block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_CLK_HZ 25000000
`define TCC_CTRL_OFS 8'h00
`define TCC_MODE_OFS 8'h04
`define TCC_VALUE_OFS 8'h08
`define TCC_STAT_OFS 8'h0C
`define TCC_RC_OFS 8'h10
`define TCC_RB_OFS 8'h14
`define TCC_CHAN_STRIDE 8'h20
`define TCC_CHAN_SPAN 2'h3
`define TCC_BCTRL_OFS 8'h60
`define TCC_BMODE_OFS 8'h64
`define TCC_CTRL_ON 0
`define TCC_CTRL_OFF 1
`define TCC_CTRL_TRIG 2
`define TCC_MODE_SEL_LO 0
`define TCC_MODE_SEL_HI 2
`define TCC_MODE_INV 3
`define TCC_MODE_BURST_LO 4
`define TCC_MODE_BURST_HI 5
`define TCC_MODE_HALT_B 6
`define TCC_MODE_OFF_B 7
`define TCC_MODE_HALT_C 8
`define TCC_MODE_OFF_C 9
`define TCC_MODE_WAVE 15
`define TCC_STAT_WRAP 0
`define TCC_STAT_LOADB 1
`define TCC_STAT_MATCHC 2
`define TCC_STAT_ON 16
`define TCC_BCTRL_SYNC 0
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`define TCC_DIV_W 10
`endif

//--- hdl/tcc_pkg.sv
// Types shared by the timer block files
package tcc_pkg;
    typedef enum logic [2:0] {
        TCC_SRC_DIV2 = 3'h0,
        TCC_SRC_DIV8 = 3'h1,
        TCC_SRC_DIV32 = 3'h2,
        TCC_SRC_DIV128 = 3'h3,
        TCC_SRC_DIV1024 = 3'h4,
        TCC_SRC_EXT0 = 3'h5,
        TCC_SRC_EXT1 = 3'h6,
        TCC_SRC_EXT2 = 3'h7
    } tcc_src_t;

    typedef struct packed {
        logic wave;
        logic offOnMatchC;
        logic haltOnMatchC;
        logic offOnLoadB;
        logic haltOnLoadB;
        logic [1:0] burst;
        logic clkInvert;
        tcc_src_t src;
    } tcc_mode_t;

    typedef struct packed {
        logic clkOnCmd;
        logic clkOffCmd;
        logic softTriggerCmd;
    } tcc_cmd_t;

    typedef enum logic [1:0] {
        TCC_B_IDLE = 2'b00,
        TCC_B_RUN = 2'b01,
        TCC_B_RESP = 2'b11
    } tcc_bus_st_t;
endpackage

//--- hdl/tcc_channel.sv
// One timer channel: clock path, enable/start control and 16-bit counter
`timescale 1ns/100ps
`include "tcc_defs.svh"
module tcc_channel #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [4:0] tapPulse,
    input wire logic [2:0] extClkIn,
    input wire tcc_pkg::tcc_mode_t mode,
    input wire tcc_pkg::tcc_cmd_t cmd,
    input wire logic syncIn,
    input wire logic [WIDTH-1:0] matchC,
    input wire logic loadB,
    output logic [WIDTH-1:0] countValue,
    output logic clkOnStatus,
    output logic wrapEvt,
    output logic matchCEvt
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic enabled;
        logic running;
        logic trigPend;
        logic prevLevel;
    } tcc_ch_state_t;

    tcc_ch_state_t st;
    tcc_ch_state_t next_st;
    logic level;
    logic gate;
    logic edgeHit;
    logic trig;
    logic haltEvt;
    logic offEvt;

    always_comb
    begin
        next_st = st;
        wrapEvt = 1'b0;
        matchCEvt = 1'b0;
        case (mode.src)
            tcc_pkg::TCC_SRC_EXT0: level = extClkIn[0];
            tcc_pkg::TCC_SRC_EXT1: level = extClkIn[1];
            tcc_pkg::TCC_SRC_EXT2: level = extClkIn[2];
            default: level = 1'b0;
        endcase
        level = level ^ mode.clkInvert;
        case (mode.burst)
            2'h1: gate = extClkIn[0];
            2'h2: gate = extClkIn[1];
            2'h3: gate = extClkIn[2];
            default: gate = 1'b1;
        endcase
        // internal taps are edge pulses already
        if (mode.src <= tcc_pkg::TCC_SRC_DIV1024)
            edgeHit = tapPulse[mode.src] & gate;
        else
            // rising edge of sampled external clock, falling edge when clkInvert is set
            edgeHit = level & ~st.prevLevel & gate;
        next_st.prevLevel = level;
        trig = cmd.softTriggerCmd | syncIn;
        haltEvt = (~mode.wave & loadB & mode.haltOnLoadB) |
            (mode.wave & st.running & st.count == matchC & mode.haltOnMatchC);
        offEvt = (~mode.wave & loadB & mode.offOnLoadB) |
            (mode.wave & st.running & st.count == matchC & mode.offOnMatchC);
        if (cmd.clkOffCmd | offEvt)
            next_st.enabled = 1'b0;
        else if (cmd.clkOnCmd)
            next_st.enabled = 1'b1;
        if (st.enabled | (cmd.clkOnCmd & ~cmd.clkOffCmd))
        begin
            if (trig)
            begin
                next_st.running = 1'b1;
                next_st.trigPend = 1'b1;
            end
            else if (haltEvt)
                next_st.running = 1'b0;
        end
        if (~next_st.enabled)
            next_st.running = 1'b0;
        if (st.running & st.enabled & edgeHit)
        begin
            if (st.trigPend)
            begin
                next_st.count = '0;
                next_st.trigPend = trig;
            end
            else
            begin
                next_st.count = st.count + 1'b1;
                wrapEvt = &st.count;
            end
            matchCEvt = mode.wave & (next_st.count == matchC);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign countValue = st.count;
    assign clkOnStatus = st.enabled;
endmodule

//--- testbench/tcc_ext_clk_model.sv
// External clock source standing at the timer clock pins
`timescale 1ns/100ps
module tcc_ext_clk_model #(
    parameter int HALF = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic run,
    output logic [2:0] pinClk
);
    int phase;

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n || !run)
        begin
            phase <= 0;
            pinClk <= 3'h0;
        end
        else if (phase == HALF - 1)
        begin
            phase <= 0;
            pinClk <= ~pinClk;
        end
        else
            phase <= phase + 1;
    end
endmodule

//--- testbench/tcc_block_chk.sv
// Bus and pin checker for the timer block
`timescale 1ns/100ps
`include "tcc_defs.svh"
module tcc_block_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] multiIoBOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response late or early");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");
    a_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp == `TCC_RESP_OKAY || s_axi_rresp == `TCC_RESP_SLVERR)
        else $error("bad read response");
    a_b_input_only: assert property (multiIoBOe == 3'h0)
        else $error("pin B driven");
endmodule

bind tcc_block tcc_block_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .multiIoBOe(multiIoBOe));

//--- testbench/test_tcc_block.sv
// Self-checking bench for the three-channel timer block
`timescale 1ns/100ps
`include "tcc_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_tcc_block;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0] resp;
    } tcc_row_t;
    tcc_row_t rows [5] = '{
        '{8'h24, 32'h0000_8305, 32'h0000_8305, `TCC_RESP_OKAY},
        '{8'h50, 32'h0000_1234, 32'h0000_1234, `TCC_RESP_OKAY},
        '{8'h64, 32'h0000_0015, 32'h0000_0015, `TCC_RESP_OKAY},
        '{8'h64, 32'h0000_0000, 32'h0000_0000, `TCC_RESP_OKAY},
        '{8'h70, 32'h0000_0001, 32'h0000_0000, `TCC_RESP_SLVERR}};
    int divs [5] = '{2, 8, 32, 128, 1024};
    logic ref_clk, arst_n, extRun;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] timerClkPin, loadB, multiIoAOut, multiIoAOe, multiIoBOe, chanIrq;
    int error_cnt, total_checks, cyc, tRd;

    tcc_block dut (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timerClkPin(timerClkPin), .multiIoAIn(3'h0), .multiIoBIn(3'h0),
        .loadB(loadB), .multiIoAOut(multiIoAOut), .multiIoAOe(multiIoAOe), .multiIoBOe(multiIoBOe),
        .chanIrq(chanIrq));
    tcc_ext_clk_model ext (.ref_clk(ref_clk), .arst_n(arst_n), .run(extRun), .pinClk(timerClkPin));

    initial
    begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Hang guard, roughly twice the expected run
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic awTaken;
        logic wTaken;
        awTaken = 1'b0;
        wTaken = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        // Readies and answers are registered: the falling-edge level holds at the next rising edge
        while (!(awTaken && wTaken))
        begin
            @(negedge ref_clk);
            awTaken = awTaken | s_axi_awready;
            wTaken = wTaken | s_axi_wready;
            @(posedge ref_clk);
            if (awTaken)
                s_axi_awvalid <= 0;
            if (wTaken)
                s_axi_wvalid <= 0;
        end
        do @(negedge ref_clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        @(posedge ref_clk);
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(negedge ref_clk); while (!s_axi_arready);
        @(posedge ref_clk);
        s_axi_arvalid <= 0;
        do @(negedge ref_clk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        tRd = cyc;
        @(posedge ref_clk);
        s_axi_rready <= 0;
    endtask

    // Equal spans of 1024 cycles hold a whole number of periods of every source
    task automatic measure(input logic [7:0] base, input int div);
        logic [15:0] first;
        int t0;
        // Let a pending trigger clear the count before the window opens
        repeat (16) @(posedge ref_clk);
        do @(posedge ref_clk); while (cyc % 1024 != 0);
        rd(base + 8'h08);
        first = rv[15:0];
        t0 = tRd;
        do @(posedge ref_clk); while (cyc % 1024 != 0);
        rd(base + 8'h08);
        `CHK(16'(rv[15:0] - first), (div == 0) ? 16'h0 : 16'((tRd - t0) / div))
    endtask

    task automatic pulseLoad();
        @(posedge ref_clk);
        loadB <= 3'b001;
        @(posedge ref_clk);
        loadB <= 3'b000;
    endtask

    initial
    begin
        {arst_n, extRun, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, loadB, error_cnt, total_checks, cyc} = 0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1;
        rd(8'h0C);
        `CHK(rv, 32'h0000_0000)
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            `CHK(rs, rows[i].resp)
            rd(rows[i].addr);
            `CHK({rv, rs}, {rows[i].rdata, rows[i].resp})
        end
        `CHK(multiIoAOe, 3'b010)
        wr(8'h00, 32'h0000_0001);
        rd(8'h0C);
        `CHK(rv, 32'h0001_0000)
        wr(8'h00, 32'h0000_0004);
        for (int s = 0; s < 5; s++)
        begin
            wr(8'h04, 32'(s));
            measure(8'h00, divs[s]);
        end
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0002);
        rd(8'h0C);
        `CHK(rv, 32'h0000_0000)
        measure(8'h00, 0);
        wr(8'h00, 32'h0000_0004);
        measure(8'h00, 0);
        wr(8'h00, 32'h0000_0003);
        rd(8'h0C);
        `CHK(rv, 32'h0000_0000)
        wr(8'h00, 32'h0000_0001);
        wr(8'h04, 32'h0000_0040);
        wr(8'h00, 32'h0000_0004);
        pulseLoad();
        rd(8'h0C);
        `CHK(rv, 32'h0001_0002)
        measure(8'h00, 0);
        wr(8'h00, 32'h0000_0004);
        measure(8'h00, 2);
        wr(8'h04, 32'h0000_0080);
        pulseLoad();
        rd(8'h0C);
        `CHK(rv, 32'h0000_0002)
        rd(8'h0C);
        `CHK(rv, 32'h0000_0000)
        wr(8'h24, 32'h0000_0001);
        wr(8'h20, 32'h0000_0001);
        wr(8'h60, 32'h0000_0001);
        measure(8'h20, 8);
        wr(8'h44, 32'h0000_0005);
        wr(8'h40, 32'h0000_0001);
        extRun <= 1;
        wr(8'h40, 32'h0000_0004);
        measure(8'h40, 8);
        wr(8'h44, 32'h0000_000D);
        measure(8'h40, 8);
        extRun <= 0;
        wr(8'h44, 32'h0000_0010);
        measure(8'h40, 0);
        // Waveform channel runs up to C, toggles output A and switches itself off
        wr(8'h10, 32'h0000_0010);
        wr(8'h04, 32'h0000_8200);
        wr(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0004);
        repeat (64) @(posedge ref_clk);
        rd(8'h08);
        `CHK(rv, 32'h0000_0010)
        rd(8'h0C);
        `CHK(rv, 32'h0000_0004)
        `CHK({multiIoAOe, multiIoAOut}, 6'h09)
        wr(8'h0C, 32'h0000_0002);
        pulseLoad();
        @(negedge ref_clk);
        `CHK(chanIrq, 3'b001)
        rd(8'h0C);
        `CHK({chanIrq, rv}, {3'b000, 32'h0000_0002})
        conclude();
    end
endmodule
